// *** rtl/cwa_home.sv ***
// cwa_home: home agent / target, executes writes and atomics on its lines.
// assumes one request at a time and naturally aligned atomic addresses.
// Operation
// - partial writes send lane enables with data
// - uncached partial: lanes enabled inside size only
// - uncached full: no enables, all lanes written
// - coherent partial: lanes enabled inside size only
// - coherent full: no enables, all lanes written
// - copy-backs complete without snooping anyone
// - partial copy-back enables mark dirty bytes
// - partial copy-back only with partial states
// - full copy-back, no enables, two forms
// - clean-retaining copy-back, full line, no enables
// - evict with data, full line, no enables
// - atomic store applies op, no data back
// - atomic load returns original, same size
// - atomic swap stores operand, returns original
// - compare operand sits at addressed lane
// - compare swaps on match, returns half size
// - self-snoop atomics snoop the requester
// - device/non-cacheable self-snoop: no snoop
// - requester writes back or uses self-snoop
// - write opcodes fixed, others reserved
// - atomic sub-op in bits 2:0, endian bit3
// - write completion carries no data
`timescale 1ns/1ps
`default_nettype none
module cwa_home (
	// clock and reset
	input  wire logic  CORE_CLK,
	input  wire logic  RESET,
	// status
	output logic       PROTOCOL_ERROR,
	// link
	cwa_link_if.home   link
);
	typedef enum {H_IDLE, H_SNOOP, H_EXEC} cwa_hstate_t;
	cwa_hstate_t                         state;
	logic [cwa_pkg::DATA_W-1:0]          mem [cwa_pkg::LINES];
	logic [7:0]                          op;
	logic [cwa_pkg::ADDR_W-1:0]          addr;
	logic [cwa_pkg::SIZE_W-1:0]          size;
	logic [cwa_pkg::DATA_W-1:0]          data;
	logic [cwa_pkg::LINE_BYTES-1:0]      be;
	cwa_pkg::cwa_class_t                 cls;
	cwa_pkg::cwa_class_t                 in_cls;

	// execution datapath
	logic [cwa_pkg::DATA_W-1:0]          line;
	logic [cwa_pkg::DATA_W-1:0]          next_line;
	logic [cwa_pkg::OFF_W-1:0]           off;
	logic [cwa_pkg::SIZE_W-1:0]          vsize;
	logic [cwa_pkg::OFF_W-1:0]           half;
	logic [6:0]                          vbytes;
	logic [cwa_pkg::ATOM_W-1:0]          mask;
	logic [cwa_pkg::ATOM_W-1:0]          old;
	logic [cwa_pkg::ATOM_W-1:0]          opnd;
	logic [cwa_pkg::ATOM_W-1:0]          swp;
	logic [cwa_pkg::ATOM_W-1:0]          a;
	logic [cwa_pkg::ATOM_W-1:0]          b;
	logic [cwa_pkg::ATOM_W-1:0]          a_top;
	logic [cwa_pkg::ATOM_W-1:0]          b_top;
	logic [cwa_pkg::ATOM_W-1:0]          res;
	logic                                big;
	logic                                bad;
	logic                                store_en;
	logic                                is_atom;

	function automatic logic [cwa_pkg::ATOM_W-1:0] swap_bytes(
		input logic [cwa_pkg::ATOM_W-1:0] x,
		input logic [6:0]                 n
	);
		logic [cwa_pkg::ATOM_W-1:0] y;
		y = '0;
		for (int i = 0; i < cwa_pkg::ATOM_BYTES; i++)
			if (7'(i) < n)
				y[i*8 +: 8] = x[(32'(n) - 1 - i)*8 +: 8];
		return y;
	endfunction : swap_bytes

	assign in_cls = cwa_pkg::cwa_classify(link.req_opcode);
	assign cls    = cwa_pkg::cwa_classify(op);
	assign is_atom = cls inside {cwa_pkg::CLS_ATOM_ST, cwa_pkg::CLS_ATOM_LD,
		cwa_pkg::CLS_ATOM_SW, cwa_pkg::CLS_ATOM_CMP};

	always_comb
	begin
		line   = mem[addr[cwa_pkg::ADDR_W-1:cwa_pkg::OFF_W]];
		off    = addr[cwa_pkg::OFF_W-1:0];
		// compare carries two operands, each half the request size
		vsize  = (cls == cwa_pkg::CLS_ATOM_CMP) ? size - 3'h1 : size;
		vbytes = 7'(1) << vsize;
		half   = cwa_pkg::OFF_W'(vbytes);
		mask   = (vbytes >= 7'(cwa_pkg::ATOM_BYTES)) ? '1
			: ((cwa_pkg::ATOM_W'(1) << {vbytes, 3'h0}) - cwa_pkg::ATOM_W'(1));
		old    = cwa_pkg::ATOM_W'(line >> {off, 3'h0}) & mask;
		opnd   = cwa_pkg::ATOM_W'(data >> {off, 3'h0}) & mask;
		swp    = cwa_pkg::ATOM_W'(data >> {off ^ half, 3'h0}) & mask;
		big    = op[cwa_pkg::ENDIAN_BIT]
			&& !(cwa_pkg::cwa_subop_t'(op[2:0]) inside {cwa_pkg::SUB_CLR, cwa_pkg::SUB_EOR, cwa_pkg::SUB_SET});
		a      = big ? swap_bytes(old, vbytes) : old;
		b      = big ? swap_bytes(opnd, vbytes) : opnd;
		// align the operands at the top so sign and magnitude compare at any size
		a_top  = a << (cwa_pkg::ATOM_W - 32'(vbytes) * 8);
		b_top  = b << (cwa_pkg::ATOM_W - 32'(vbytes) * 8);
		case (cwa_pkg::cwa_subop_t'(op[2:0]))
			cwa_pkg::SUB_ADD:  res = (a + b) & mask;
			cwa_pkg::SUB_CLR:  res = a & ~b;
			cwa_pkg::SUB_EOR:  res = a ^ b;
			cwa_pkg::SUB_SET:  res = a | b;
			cwa_pkg::SUB_SMAX: res = ($signed(a_top) > $signed(b_top)) ? a : b;
			cwa_pkg::SUB_SMIN: res = ($signed(a_top) < $signed(b_top)) ? a : b;
			cwa_pkg::SUB_UMAX: res = (a_top > b_top) ? a : b;
			cwa_pkg::SUB_UMIN: res = (a_top < b_top) ? a : b;
			default:           res = a;
		endcase
		if (big)
			res = swap_bytes(res, vbytes);
		case (cls)
			cwa_pkg::CLS_ATOM_ST, cwa_pkg::CLS_ATOM_LD:
				bad = size > cwa_pkg::SIZE_ATOM_MAX;
			cwa_pkg::CLS_ATOM_SW:
				bad = size > cwa_pkg::SIZE_ATOM_MAX;
			cwa_pkg::CLS_ATOM_CMP:
				bad = size < cwa_pkg::SIZE_CMP_MIN || size > cwa_pkg::SIZE_CMP_MAX;
			cwa_pkg::CLS_RESERVED:
				bad = 1'b1;
			default:
				bad = 1'b0;
		endcase
		store_en = 1'b1;
		if (cls == cwa_pkg::CLS_ATOM_SW)
			res = opnd;
		else if (cls == cwa_pkg::CLS_ATOM_CMP)
		begin
			res      = swp;
			store_en = (old == opnd);
		end
		next_line = line;
		for (int i = 0; i < cwa_pkg::LINE_BYTES; i++)
		begin
			if (!bad && is_atom && store_en && 7'(i) >= 7'(off) && 7'(i) < 7'(off) + vbytes)
				next_line[i*8 +: 8] = res[(i - 32'(off))*8 +: 8];
			else if (!bad && !is_atom && (cls inside {cwa_pkg::CLS_WR_FULL, cwa_pkg::CLS_CB_FULL} || be[i]))
				next_line[i*8 +: 8] = data[i*8 +: 8];
		end
	end

	// request intake, self-snoop and completion
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state              <= H_IDLE;
			link.req_ready     <= 1'b0;
			link.comp_valid    <= 1'b0;
			link.comp_has_data <= 1'b0;
			link.comp_error    <= 1'b0;
			link.comp_data     <= '0;
			link.snp_valid     <= 1'b0;
			link.snp_addr      <= '0;
			op                 <= '0;
			addr               <= '0;
			size               <= '0;
			data               <= '0;
			be                 <= '0;
		end
		else
		begin
			link.comp_valid <= 1'b0;
			link.snp_valid  <= 1'b0;
			case (state)
				H_IDLE:
				begin
					link.req_ready <= 1'b1;
					if (link.req_valid && link.req_ready)
					begin
						link.req_ready <= 1'b0;
						op   <= link.req_opcode;
						addr <= link.req_addr;
						size <= link.req_size;
						data <= link.req_data;
						// enables only count when the requester says they are present
						be   <= link.req_be_present ? link.req_be : '1;
						// presence is not tracked here, so a hinted atomic always snoops unless it is non-cacheable
						if (link.req_opcode[cwa_pkg::SELF_SNOOP_HINT_BIT] && in_cls != cwa_pkg::CLS_RESERVED
							&& !link.req_noncacheable)
						begin
							link.snp_valid <= 1'b1;
							link.snp_addr  <= link.req_addr;
							state          <= H_SNOOP;
						end
						else
							state <= H_EXEC;
					end
				end
				H_SNOOP:
				begin
					if (link.snp_ack)
						state <= H_EXEC;
				end
				H_EXEC:
				begin
					link.comp_valid    <= 1'b1;
					link.comp_error    <= bad;
					link.comp_has_data <= !bad && cls inside {cwa_pkg::CLS_ATOM_LD, cwa_pkg::CLS_ATOM_SW,
						cwa_pkg::CLS_ATOM_CMP};
					link.comp_data     <= (bad || !(cls inside {cwa_pkg::CLS_ATOM_LD, cwa_pkg::CLS_ATOM_SW,
						cwa_pkg::CLS_ATOM_CMP})) ? '0 : old;
					link.req_ready     <= 1'b1;
					state              <= H_IDLE;
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	// backing lines: no reset, contents are data not control
	always_ff @(posedge CORE_CLK)
	begin
		if (state == H_EXEC)
			mem[addr[cwa_pkg::ADDR_W-1:cwa_pkg::OFF_W]] <= next_line;
	end

	// sticky protocol error flag
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
			PROTOCOL_ERROR <= 1'b0;
		else if (state == H_EXEC && bad)
			PROTOCOL_ERROR <= 1'b1;
	end
endmodule : cwa_home
`default_nettype wire

// *** rtl/cwa_pkg.sv ***
// cwa_pkg: opcodes, sizes and request classes shared by both link ends.
// assumes one line of 64 bytes and one request outstanding on the link.
package cwa_pkg;
	localparam int LINE_BYTES = 64;
	localparam int DATA_W     = 512;
	localparam int ADDR_W     = 10;
	localparam int OFF_W      = 6;
	localparam int IDX_W      = 4;
	localparam int LINES      = 16;
	localparam int ATOM_W     = 128;
	localparam int ATOM_BYTES = 16;
	localparam int SIZE_W     = 3;
	localparam int SELF_SNOOP_HINT_BIT  = 7;
	localparam int ENDIAN_BIT = 3;

	// write opcodes
	localparam logic [7:0] OP_UNCACHED_PTL  = 8'h20;
	localparam logic [7:0] OP_UNCACHED_FULL = 8'h21;
	localparam logic [7:0] OP_COHERENT_PTL  = 8'h22;
	localparam logic [7:0] OP_COHERENT_FULL = 8'h23;
	localparam logic [7:0] OP_COPYBACK_PTL  = 8'h24;
	localparam logic [7:0] OP_COPYBACK_UD   = 8'h25;
	localparam logic [7:0] OP_COPYBACK_SD   = 8'h27;
	localparam logic [7:0] OP_CLEAN_RETAIN  = 8'h2B;
	localparam logic [7:0] OP_EVICT_DATA    = 8'h2D;
	// atomic opcodes, bit 7 is the self-snoop hint
	localparam logic [3:0] OP_ATOM_STORE_HI = 4'h4;
	localparam logic [3:0] OP_ATOM_LOAD_HI  = 4'h5;
	localparam logic [6:0] OP_ATOM_SWAP     = 7'h60;
	localparam logic [6:0] OP_ATOM_CMP      = 7'h61;

	// size field is log2 of bytes
	localparam logic [SIZE_W-1:0] SIZE_LINE     = 3'h6;
	localparam logic [SIZE_W-1:0] SIZE_ATOM_MAX = 3'h3;
	localparam logic [SIZE_W-1:0] SIZE_CMP_MIN  = 3'h1;
	localparam logic [SIZE_W-1:0] SIZE_CMP_MAX  = 3'h5;

	typedef enum logic [2:0] {
		SUB_ADD, SUB_CLR, SUB_EOR, SUB_SET, SUB_SMAX, SUB_SMIN, SUB_UMAX, SUB_UMIN
	} cwa_subop_t;

	typedef enum logic [3:0] {
		CLS_WR_PTL, CLS_WR_FULL, CLS_CB_PTL, CLS_CB_FULL,
		CLS_ATOM_ST, CLS_ATOM_LD, CLS_ATOM_SW, CLS_ATOM_CMP, CLS_RESERVED
	} cwa_class_t;

	function automatic cwa_class_t cwa_classify(input logic [7:0] op);
		cwa_class_t c;
		c = CLS_RESERVED;
		case (op)
			OP_UNCACHED_PTL, OP_COHERENT_PTL:   c = CLS_WR_PTL;
			OP_UNCACHED_FULL, OP_COHERENT_FULL: c = CLS_WR_FULL;
			OP_COPYBACK_PTL:                    c = CLS_CB_PTL;
			OP_COPYBACK_UD, OP_COPYBACK_SD,
			OP_CLEAN_RETAIN, OP_EVICT_DATA:     c = CLS_CB_FULL;
			default:
			begin
				if (op[6:4] == OP_ATOM_STORE_HI[2:0])
					c = CLS_ATOM_ST;
				else if (op[6:4] == OP_ATOM_LOAD_HI[2:0])
					c = CLS_ATOM_LD;
				else if (op[6:0] == OP_ATOM_SWAP)
					c = CLS_ATOM_SW;
				else if (op[6:0] == OP_ATOM_CMP)
					c = CLS_ATOM_CMP;
			end
		endcase
		return c;
	endfunction : cwa_classify
endpackage : cwa_pkg

// *** rtl/cwa_link_if.sv ***
// cwa_link_if: request, completion and self-snoop wires between the ends.
// assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
interface cwa_link_if;
	logic                            req_valid;
	logic                            req_ready;
	logic [7:0]                      req_opcode;
	logic [cwa_pkg::ADDR_W-1:0]      req_addr;
	logic [cwa_pkg::SIZE_W-1:0]      req_size;
	logic [cwa_pkg::DATA_W-1:0]      req_data;
	logic [cwa_pkg::LINE_BYTES-1:0]  req_be;
	logic                            req_be_present;
	logic                            req_noncacheable;
	logic                            comp_valid;
	logic                            comp_has_data;
	logic                            comp_error;
	logic [cwa_pkg::ATOM_W-1:0]      comp_data;
	logic                            snp_valid;
	logic [cwa_pkg::ADDR_W-1:0]      snp_addr;
	logic                            snp_ack;

	modport requester (
		output req_valid, req_opcode, req_addr, req_size, req_data, req_be, req_be_present, req_noncacheable,
		input  req_ready, comp_valid, comp_has_data, comp_error, comp_data, snp_valid, snp_addr,
		output snp_ack
	);
	modport home (
		input  req_valid, req_opcode, req_addr, req_size, req_data, req_be, req_be_present, req_noncacheable,
		output req_ready, comp_valid, comp_has_data, comp_error, comp_data, snp_valid, snp_addr,
		input  snp_ack
	);
endinterface : cwa_link_if
`default_nettype wire

// *** rtl/cwa_requester.sv ***
// cwa_requester: requesting agent, turns user commands into link requests.
// assumes the user cache answers snoops and picks the opcode by line state.
`timescale 1ns/1ps
`default_nettype none
module cwa_requester #(
	parameter bit PARTIAL_STATES_OK = 1'b1
) (
	// clock and reset
	input  wire logic                            CORE_CLK,
	input  wire logic                            RESET,
	// user command
	input  wire logic                            CMD_VALID,
	output logic                                 CMD_READY,
	input  wire logic [7:0]                      CMD_OPCODE,
	input  wire logic [cwa_pkg::ADDR_W-1:0]      CMD_ADDR,
	input  wire logic [cwa_pkg::SIZE_W-1:0]      CMD_SIZE,
	input  wire logic [cwa_pkg::DATA_W-1:0]      CMD_DATA,
	input  wire logic [cwa_pkg::LINE_BYTES-1:0]  CMD_DIRTY_BE,
	input  wire logic                            CMD_NONCACHEABLE,
	// user response
	output logic                                 RSP_VALID,
	output logic                                 RSP_ERROR,
	output logic [cwa_pkg::ATOM_W-1:0]           RSP_DATA,
	// user cache snoop
	output logic                                 SNOOP_REQ,
	output logic [cwa_pkg::ADDR_W-1:0]           SNOOP_ADDR,
	input  wire logic                            SNOOP_DONE,
	// link
	cwa_link_if.requester                        link
);
	typedef enum {R_IDLE, R_SEND, R_WAIT} cwa_rstate_t;
	cwa_rstate_t                      state;
	cwa_pkg::cwa_class_t              cls;
	logic [cwa_pkg::LINE_BYTES-1:0]   lane_mask;
	logic [6:0]                       nbytes;

	assign cls = cwa_pkg::cwa_classify(CMD_OPCODE);

	// lanes inside the stated size from the addressed byte on
	always_comb
	begin
		nbytes = 7'(1) << CMD_SIZE;
		for (int i = 0; i < cwa_pkg::LINE_BYTES; i++)
			lane_mask[i] = (7'(i) >= 7'(CMD_ADDR[cwa_pkg::OFF_W-1:0]))
				&& (7'(i) < 7'(CMD_ADDR[cwa_pkg::OFF_W-1:0]) + nbytes);
	end

	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state                 <= R_IDLE;
			CMD_READY             <= 1'b0;
			RSP_VALID             <= 1'b0;
			RSP_ERROR             <= 1'b0;
			RSP_DATA              <= '0;
			link.req_valid        <= 1'b0;
			link.req_opcode       <= '0;
			link.req_addr         <= '0;
			link.req_size         <= '0;
			link.req_data         <= '0;
			link.req_be           <= '0;
			link.req_be_present   <= 1'b0;
			link.req_noncacheable <= 1'b0;
		end
		else
		begin
			RSP_VALID <= 1'b0;
			case (state)
				R_IDLE:
				begin
					CMD_READY <= 1'b1;
					if (CMD_VALID && CMD_READY)
					begin
						if (cls == cwa_pkg::CLS_CB_PTL && !PARTIAL_STATES_OK)
						begin
							// refused locally, nothing goes out on the link
							RSP_VALID <= 1'b1;
							RSP_ERROR <= 1'b1;
							RSP_DATA  <= '0;
						end
						else
						begin
							CMD_READY             <= 1'b0;
							link.req_valid        <= 1'b1;
							link.req_opcode       <= CMD_OPCODE;
							link.req_addr         <= CMD_ADDR;
							link.req_size         <= CMD_SIZE;
							// compare operand already placed at the addressed lane
							link.req_data         <= CMD_DATA;
							link.req_noncacheable <= CMD_NONCACHEABLE;
							case (cls)
								cwa_pkg::CLS_WR_PTL:
								begin
									link.req_be         <= lane_mask;
									link.req_be_present <= 1'b1;
								end
								cwa_pkg::CLS_CB_PTL:
								begin
									link.req_be         <= CMD_DIRTY_BE;
									link.req_be_present <= 1'b1;
									link.req_size       <= cwa_pkg::SIZE_LINE;
								end
								cwa_pkg::CLS_WR_FULL, cwa_pkg::CLS_CB_FULL:
								begin
									link.req_be         <= '0;
									link.req_be_present <= 1'b0;
									link.req_size       <= cwa_pkg::SIZE_LINE;
								end
								default:
								begin
									link.req_be         <= '0;
									link.req_be_present <= 1'b0;
								end
							endcase
							state <= R_SEND;
						end
					end
				end
				R_SEND:
				begin
					if (link.req_ready)
					begin
						link.req_valid <= 1'b0;
						state          <= R_WAIT;
					end
				end
				R_WAIT:
				begin
					if (link.comp_valid)
					begin
						RSP_VALID <= 1'b1;
						RSP_ERROR <= link.comp_error;
						RSP_DATA  <= link.comp_has_data ? link.comp_data : '0;
						CMD_READY <= 1'b1;
						state     <= R_IDLE;
					end
				end
				default: state <= R_IDLE;
			endcase
		end
	end

	// snoop pass-through to the user cache
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			SNOOP_REQ    <= 1'b0;
			SNOOP_ADDR   <= '0;
			link.snp_ack <= 1'b0;
		end
		else
		begin
			SNOOP_REQ    <= link.snp_valid;
			link.snp_ack <= SNOOP_DONE;
			if (link.snp_valid)
				SNOOP_ADDR <= link.snp_addr;
		end
	end
endmodule : cwa_requester
`default_nettype wire

// *** tb/cwa_link_checker.sv ***
// cwa_link_checker: timing and content properties of the link between the two ends.
// assumes it is instantiated beside the link interface, on the core clock and reset.
`timescale 1ns/1ps
`default_nettype none
module cwa_link_checker (
	// clock and reset
	input  wire logic                            CORE_CLK,
	input  wire logic                            RESET,
	// request
	input  wire logic                            req_valid,
	input  wire logic                            req_ready,
	input  wire logic [7:0]                      req_opcode,
	input  wire logic [cwa_pkg::SIZE_W-1:0]      req_size,
	input  wire logic                            req_be_present,
	input  wire logic                            req_noncacheable,
	// completion and snoop
	input  wire logic                            comp_valid,
	input  wire logic                            comp_has_data,
	input  wire logic                            comp_error,
	input  wire logic [cwa_pkg::ATOM_W-1:0]      comp_data,
	input  wire logic                            snp_valid,
	input  wire logic                            snp_ack
);
	logic       take;
	logic [7:0] last_op;

	assign take = req_valid && req_ready;

	// completion kind follows the last request taken, one outstanding at a time
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
			last_op <= 8'h00;
		else if (take)
			last_op <= req_opcode;
	end

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	a_full_no_enables: assert property (
		req_valid && req_opcode inside {8'h21, 8'h23, 8'h25, 8'h27, 8'h2B, 8'h2D}
		|-> !req_be_present && req_size == cwa_pkg::SIZE_LINE) else $error("full write carries enables");
	a_partial_enables: assert property (
		req_valid && req_opcode inside {8'h20, 8'h22, 8'h24} |-> req_be_present)
		else $error("partial write without enables");
	a_copyback_no_snoop: assert property (
		take && req_opcode[7:4] == 4'h2 |-> ##1 !snp_valid ##1 comp_valid && !comp_has_data)
		else $error("write snooped or completed late");
	a_self_snoop: assert property (
		take && req_opcode[7] && !req_noncacheable
		&& (req_opcode[6:4] inside {3'h4, 3'h5} || req_opcode[6:0] inside {7'h60, 7'h61}) |=> snp_valid)
		else $error("self-snoop atomic not snooped");
	a_nc_no_snoop: assert property (
		take && req_noncacheable |-> ##1 !snp_valid ##1 comp_valid) else $error("non-cacheable request snooped");
	a_ack_to_comp: assert property (
		snp_ack |-> ##2 comp_valid) else $error("no completion after snoop answer");
	a_write_no_data: assert property (
		comp_valid && last_op[7:4] == 4'h2 |-> !comp_has_data && comp_data == '0)
		else $error("write completion carries data");
	a_store_no_data: assert property (
		comp_valid && last_op[6:4] == 3'h4 |-> !comp_has_data) else $error("store completion carries data");
	a_load_data: assert property (
		comp_valid && last_op[6:4] == 3'h5 && !comp_error |-> comp_has_data) else $error("load completion empty");
	a_bad_size_err: assert property (
		take && req_opcode[7:4] inside {4'h4, 4'h5} && req_size > cwa_pkg::SIZE_ATOM_MAX
		|-> ##2 comp_valid && comp_error) else $error("oversized atomic not refused");
endmodule : cwa_link_checker
`default_nettype wire

// *** tb/tb_coherent_write_atomic_requests.sv ***
// tb_coherent_write_atomic_requests: drives the requester's user side; the link joins it to the home.
// assumes one command at a time and a user cache that answers each snoop one cycle later.
`timescale 1ns/1ps
`default_nettype none
module tb_coherent_write_atomic_requests;
	logic         CORE_CLK, RESET, CMD_VALID, CMD_READY, CMD_NONCACHEABLE;
	logic         RSP_VALID, RSP_ERROR, SNOOP_REQ, SNOOP_DONE, PROTOCOL_ERROR, rsp_e, seen_bp;
	logic [7:0]   CMD_OPCODE;
	logic [9:0]   CMD_ADDR, SNOOP_ADDR;
	logic [2:0]   CMD_SIZE, seen_size;
	logic [511:0] CMD_DATA;
	logic [63:0]  CMD_DIRTY_BE, seen_be;
	logic [127:0] RSP_DATA, rsp_d;
	int           fail_count, check_count, snoop_count, n0;
	localparam logic [63:0] VA = 64'h8000_0000_0000_0010;
	localparam logic [63:0] VB = 64'h0000_0000_0000_0100;
	localparam logic [63:0] VC = 64'h1234_5678_9ABC_DEF0;
	localparam logic [63:0] VW = 64'h0BAD_0000_0000_0001;

	cwa_link_if cwa_link_if_i ();
	cwa_requester #(.PARTIAL_STATES_OK(1'h1)) cwa_requester_i (.CORE_CLK(CORE_CLK), .RESET(RESET),
		.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_OPCODE(CMD_OPCODE), .CMD_ADDR(CMD_ADDR),
		.CMD_SIZE(CMD_SIZE), .CMD_DATA(CMD_DATA), .CMD_DIRTY_BE(CMD_DIRTY_BE), .CMD_NONCACHEABLE(CMD_NONCACHEABLE),
		.RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR), .RSP_DATA(RSP_DATA), .SNOOP_REQ(SNOOP_REQ),
		.SNOOP_ADDR(SNOOP_ADDR), .SNOOP_DONE(SNOOP_DONE), .link(cwa_link_if_i));
	cwa_home cwa_home_i (.CORE_CLK(CORE_CLK), .RESET(RESET), .PROTOCOL_ERROR(PROTOCOL_ERROR), .link(cwa_link_if_i));
	cwa_link_checker cwa_link_checker_i (.CORE_CLK(CORE_CLK), .RESET(RESET),
		.req_valid(cwa_link_if_i.req_valid), .req_ready(cwa_link_if_i.req_ready),
		.req_opcode(cwa_link_if_i.req_opcode), .req_size(cwa_link_if_i.req_size),
		.req_be_present(cwa_link_if_i.req_be_present), .req_noncacheable(cwa_link_if_i.req_noncacheable),
		.comp_valid(cwa_link_if_i.comp_valid), .comp_has_data(cwa_link_if_i.comp_has_data),
		.comp_error(cwa_link_if_i.comp_error), .comp_data(cwa_link_if_i.comp_data),
		.snp_valid(cwa_link_if_i.snp_valid), .snp_ack(cwa_link_if_i.snp_ack));

	initial
	begin
		CORE_CLK = 1'h0;
		forever #50 CORE_CLK = ~CORE_CLK;
	end

	// user cache answers every snoop one cycle late
	always @(posedge CORE_CLK)
		SNOOP_DONE <= #1 SNOOP_REQ;

	// wire monitor: what each taken request really carried
	always @(posedge CORE_CLK)
	begin
		if (cwa_link_if_i.snp_valid === 1'h1)
			snoop_count++;
		if (cwa_link_if_i.req_valid === 1'h1 && cwa_link_if_i.req_ready === 1'h1)
		begin
			seen_be <= cwa_link_if_i.req_be;
			seen_bp <= cwa_link_if_i.req_be_present;
			seen_size <= cwa_link_if_i.req_size;
		end
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cmd(input logic [7:0] op, input logic [9:0] a, input logic [2:0] s,
		input logic [511:0] d, input logic [63:0] be, input logic nc);
		int n;
		@(posedge CORE_CLK);
		#1;
		CMD_OPCODE = op;
		CMD_ADDR = a;
		CMD_SIZE = s;
		CMD_DATA = d;
		CMD_DIRTY_BE = be;
		CMD_NONCACHEABLE = nc;
		CMD_VALID = 1'h1;
		n = 0;
		while (CMD_READY !== 1'h1 && n < 200)
		begin
			@(posedge CORE_CLK);
			#1;
			n++;
		end
		@(posedge CORE_CLK);
		#1;
		CMD_VALID = 1'h0;
		while (RSP_VALID !== 1'h1 && n < 200)
		begin
			@(posedge CORE_CLK);
			#1;
			n++;
		end
		if (n >= 200)
		begin
			fail_count++;
			report_and_stop();
		end
		rsp_d = RSP_DATA;
		rsp_e = RSP_ERROR;
	endtask : cmd

	// read back eight bytes by an add of zero, which leaves the location alone
	task automatic peek(input logic [9:0] a);
		cmd(8'h50, a, 3'h3, '0, '0, 1'h0);
	endtask : peek

	function automatic logic [63:0] atom_exp(input int k, input logic [63:0] a, input logic [63:0] b);
		logic [63:0] ra;
		logic [63:0] rb;
		logic [63:0] r;
		ra = {<<8{a}};
		rb = {<<8{b}};
		r = ra + rb;
		case (k)
			0: return a + b;
			1: return a & ~b;
			2: return a ^ b;
			3: return a | b;
			4: return ($signed(a) > $signed(b)) ? a : b;
			5: return ($signed(a) < $signed(b)) ? a : b;
			6: return (a > b) ? a : b;
			7: return (a < b) ? a : b;
			default: return {<<8{r}};
		endcase
	endfunction : atom_exp

	task automatic t_full_writes;
		logic [7:0] ops [6] = '{8'h21, 8'h23, 8'h25, 8'h27, 8'h2B, 8'h2D};
		for (int i = 0; i < 6; i++)
		begin
			// stray enables on a full write must be ignored
			cmd(ops[i], {4'(i + 1), 6'h00}, 3'h6, {8{VC + 64'(i)}}, 64'h0000_0000_0000_0001, 1'h0);
			check(seen_bp, 1'h0);
			check(seen_size, cwa_pkg::SIZE_LINE);
			peek({4'(i + 1), 6'h08});
			check(rsp_d, 128'(VC + 64'(i)));
		end
	endtask : t_full_writes

	task automatic t_partial;
		cmd(cwa_pkg::OP_UNCACHED_FULL, 10'h200, 3'h6, {64{8'hAA}}, '0, 1'h0);
		cmd(cwa_pkg::OP_UNCACHED_PTL, 10'h204, 3'h2, {64{8'h55}}, '0, 1'h0);
		check(seen_bp, 1'h1);
		check(seen_be, 64'h0000_0000_0000_00F0);
		cmd(cwa_pkg::OP_COHERENT_PTL, 10'h208, 3'h1, {64{8'h66}}, '0, 1'h0);
		check(seen_be, 64'h0000_0000_0000_0300);
		cmd(cwa_pkg::OP_COPYBACK_PTL, 10'h200, 3'h6, {64{8'h77}}, 64'h0000_0000_0001_0001, 1'h0);
		check(seen_be, 64'h0000_0000_0001_0001);
		check(rsp_e, 1'h0);
		peek(10'h200);
		check(rsp_d, 128'(64'h5555_5555_AAAA_AA77));
		peek(10'h208);
		check(rsp_d, 128'(64'hAAAA_AAAA_AAAA_6666));
		peek(10'h210);
		check(rsp_d, 128'(64'hAAAA_AAAA_AAAA_AA77));
	endtask : t_partial

	task automatic t_subops;
		for (int k = 0; k < 9; k++)
		begin
			cmd({1'h0, cwa_pkg::OP_ATOM_SWAP}, 10'h280, 3'h3, 512'(VA), '0, 1'h0);
			if (k > 0)
				check(rsp_d, 128'(atom_exp(k - 1, VA, VB)));
			cmd((k < 8) ? {5'h0A, 3'(k)} : 8'h58, 10'h280, 3'h3, 512'(VB), '0, 1'h0);
			check(rsp_d, 128'(VA));
			peek(10'h280);
			check(rsp_d, 128'(atom_exp(k, VA, VB)));
		end
		cmd({1'h0, cwa_pkg::OP_ATOM_SWAP}, 10'h280, 3'h3, 512'(VA), '0, 1'h0);
		cmd(8'h40, 10'h280, 3'h3, 512'(VB), '0, 1'h0);
		check(rsp_d, 128'h0);
		peek(10'h280);
		check(rsp_d, 128'(VA + VB));
	endtask : t_subops

	task automatic t_compare;
		cmd({1'h0, cwa_pkg::OP_ATOM_SWAP}, 10'h2C0, 3'h3, 512'(VC), '0, 1'h0);
		cmd({1'h0, cwa_pkg::OP_ATOM_CMP}, 10'h2C0, 3'h4, 512'({VW, VC}), '0, 1'h0);
		check(rsp_d, 128'(VC));
		peek(10'h2C0);
		check(rsp_d, 128'(VW));
		// compare value no longer matches: no write, original still returned
		cmd({1'h0, cwa_pkg::OP_ATOM_CMP}, 10'h2C0, 3'h4, 512'({VA, VC}), '0, 1'h0);
		check(rsp_d, 128'(VW));
		peek(10'h2C0);
		check(rsp_d, 128'(VW));
	endtask : t_compare

	task automatic t_errors;
		check(PROTOCOL_ERROR, 1'h0);
		cmd(8'h40, 10'h2C0, 3'h4, 512'(VB), '0, 1'h0);
		check(rsp_e, 1'h1);
		check(PROTOCOL_ERROR, 1'h1);
		cmd({1'h0, cwa_pkg::OP_ATOM_CMP}, 10'h2C0, 3'h0, 512'(VB), '0, 1'h0);
		check(rsp_e, 1'h1);
		cmd(8'h2A, 10'h2C0, 3'h6, {64{8'h11}}, '0, 1'h0);
		check(rsp_e, 1'h1);
		peek(10'h2C0);
		check(rsp_d, 128'(VW));
		check(rsp_e, 1'h0);
	endtask : t_errors

	task automatic t_snoop;
		n0 = snoop_count;
		cmd(8'hD0, 10'h2C0, 3'h3, '0, '0, 1'h0);
		check(128'(snoop_count - n0), 128'h1);
		check(128'(SNOOP_ADDR), 128'h2C0);
		check(rsp_d, 128'(VW));
		cmd(8'hD0, 10'h2C0, 3'h3, '0, '0, 1'h1);
		check(128'(snoop_count - n0), 128'h1);
		cmd(cwa_pkg::OP_COPYBACK_UD, 10'h2C0, 3'h6, {64{8'h22}}, '0, 1'h0);
		check(128'(snoop_count - n0), 128'h1);
	endtask : t_snoop

	initial
	begin
		RESET = 1'h1;
		CMD_VALID = 1'h0;
		CMD_OPCODE = 8'h00;
		CMD_ADDR = 10'h000;
		CMD_SIZE = 3'h0;
		CMD_DATA = '0;
		CMD_DIRTY_BE = '0;
		CMD_NONCACHEABLE = 1'h0;
		repeat (8) @(posedge CORE_CLK);
		#1;
		RESET = 1'h0;
		t_full_writes();
		t_partial();
		t_subops();
		t_compare();
		t_errors();
		t_snoop();
		report_and_stop();
	end
endmodule : tb_coherent_write_atomic_requests
`default_nettype wire
